// file: src/cpi_front.sv
`timescale 1ns/1ps
// Behaviour
// - Type digit 0 decodes quadrature, 1 sign plus pulse, 2 forward and reverse pulse trains.
// - Direction digit 0 counts B-leading as CCW (sign high), 1 counts A-leading as CCW (sign high).
// - The direction digit only matters in quadrature mode and is ignored otherwise.
// - The pulse mode word holds 2110 by default and software keeps each digit legal.
// - At power-on the operating mode is the stored initial mode, factory 29 meaning pulse input.
// - Each pulse is scaled by numerator over denominator against 8,388,608 counts per turn of 360 degrees.
// - A changed gear ratio takes effect only after the next power cycle.
// - In pulse mode the gear scales distance and speed, in position-setting mode only distance.
// - Position loop time constant 1 to 32767 ms, default 8, smaller means more gain.
// - Speed loop time constant 1 to 32767 ms, default 2, smaller means more gain.
// - Acceleration loop gain 1 to 32767, default 5, larger means more gain.
// - Tuning values apply at once, and saving them across power loss is software's job.
// - In quadrature mode counts are multiplied by 1, 2 or 4 from the multiplier digit.
// - A changed pulse mode word is adopted only after store and power cycle.
`include "cpi_cfg.svh"
module cpi_front
(
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               pin_a,
	input  wire logic               pin_b,
	input  wire logic               pin_sign,
	input  wire cpi_pkg::cpi_cfg_t  stored_cfg,
	input  wire cpi_pkg::cpi_tune_t tune_in,
	input  wire logic               tune_load,
	output cpi_pkg::cpi_cfg_t       active_cfg,
	output cpi_pkg::cpi_tune_t      tune,
	output logic                    tune_rejected,
	output logic [7:0]              oper_mode,
	output logic                    gear_scales_speed,
	output cpi_pkg::cpi_step_t      cmd_step,
	output logic [2:0]              step_weight,
	output logic signed [31:0]      scaled_count,
	output logic [31:0]             gear_residue
);
	import cpi_pkg::*;
	typedef struct packed
	{
		logic        boot;
		cpi_cfg_t    cfg;
		cpi_tune_t   tn;
		logic        rej;
		logic [2:0]  prev;
		cpi_step_t   stp;
		logic [2:0]  wt;
		logic signed [31:0] cnt;
		logic [31:0] acc;
	} cpi_st_t;
	cpi_st_t st;
	cpi_st_t next_st;
	logic [2:0] lvl;
	cpi_in_t    in_type;
	cpi_sync u_sync
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pin      ({pin_sign, pin_b, pin_a}),
		.level    (lvl)
	);
	function automatic logic tune_ok(input logic [14:0] v);
		tune_ok = (v >= `CPI_TUNE_MIN);
	endfunction
	function automatic cpi_in_t type_of(input logic [15:0] w);
		logic [3:0] d;
		d = w[`CPI_TYPE_LSB +: 4];
		if (d == `CPI_TYPE_SIGN)
			type_of = CPI_IN_SIGN;
		else if (d == `CPI_TYPE_FWDREV)
			type_of = CPI_IN_FWDREV;
		else
			type_of = CPI_IN_QUAD;
	endfunction
	function automatic logic [2:0] mult_of(input logic [15:0] w);
		logic [3:0] d;
		d = w[`CPI_MULT_LSB +: 4];
		if (d == `CPI_MULT_X4)
			mult_of = 3'h4;
		else if (d == `CPI_MULT_X2)
			mult_of = 3'h2;
		else
			mult_of = 3'h1;
	endfunction
	assign in_type = type_of(st.cfg.mode_word);
	// ----------------------------------------
	// Decode and scaling
	// ----------------------------------------
	always_comb
	begin
		logic [2:0]  rise;
		logic        qa;
		logic        qb;
		logic        cw;
		logic        ev;
		logic        quad_ev;
		logic [1:0]  pq;
		logic [1:0]  cq;
		logic [31:0] inc;
		logic [31:0] sum;
		logic [31:0] nsteps;
		rise    = lvl & ~st.prev;
		qa      = 1'b0;
		qb      = 1'b0;
		cw      = 1'b0;
		ev      = 1'b0;
		quad_ev = 1'b0;
		pq      = {st.prev[1], st.prev[0]};
		cq      = {lvl[1], lvl[0]};
		inc     = '0;
		sum     = '0;
		nsteps  = '0;
		next_st = st;
		next_st.prev = lvl;
		next_st.stp  = '0;
		next_st.wt   = '0;
		// Latch stored settings once after reset; reset stands for a power cycle
		if (!st.boot)
		begin
			next_st.boot = 1'b1;
			next_st.cfg  = stored_cfg;
		end
		// Tuning takes effect at once, out-of-range values are dropped
		if (tune_load)
		begin
			if (tune_ok(tune_in.position_loop_time_constant) && tune_ok(tune_in.speed_loop_time_constant)
				&& tune_ok(tune_in.acceleration_loop_gain))
			begin
				next_st.tn  = tune_in;
				next_st.rej = 1'b0;
			end
			else
				next_st.rej = 1'b1;
		end
		unique case (in_type)
			CPI_IN_QUAD:
			begin
				// A-leading gives the sequence 00,01,11,10 on {b,a}
				qa = (pq != cq) && (cq[0] != pq[0]);
				qb = (pq != cq) && (cq[1] != pq[1]);
				cw = (cq[0] ^ pq[1]);
				quad_ev = (qa ^ qb);
				// Quad x1 counts A rising only, x2 both A edges, x4 all edges
				if (mult_of(st.cfg.mode_word) == 3'h4)
					ev = quad_ev;
				else if (mult_of(st.cfg.mode_word) == 3'h2)
					ev = qa && !qb;
				else
					ev = rise[0] && !qb;
				if (st.cfg.mode_word[`CPI_DIR_LSB +: 4] == 4'h0)
					next_st.stp.dir = !cw;
				else
					next_st.stp.dir = cw;
				next_st.wt = 3'h1;
			end
			CPI_IN_SIGN:
			begin
				ev = rise[1];
				next_st.stp.dir = lvl[2];
				next_st.wt = 3'h1;
			end
			CPI_IN_FWDREV:
			begin
				ev = rise[0] ^ rise[1];
				next_st.stp.dir = rise[1];
				next_st.wt = 3'h1;
			end
		endcase
		if (!ev)
			next_st.wt = '0;
		next_st.stp.step = ev;
		// Gear: fractional accumulator carries num/den per pulse
		// Four subtractions bound the depth; a ratio above four leaves the surplus in the residue, which keeps growing
		if (ev && (st.cfg.gear_den != '0))
		begin
			sum = st.acc + {17'h0, st.cfg.gear_num};
			while_loop: for (int k = 0; k < 4; k++)
			begin
				if (sum >= {17'h0, st.cfg.gear_den})
				begin
					sum    = sum - {17'h0, st.cfg.gear_den};
					nsteps = nsteps + 32'h1;
				end
			end
			next_st.acc = sum;
			inc = nsteps;
			if (next_st.stp.dir)
				next_st.cnt = st.cnt - $signed(inc);
			else
				next_st.cnt = st.cnt + $signed(inc);
		end
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.cfg.mode_word <= `CPI_MODE_DEFAULT;
			st.cfg.init_mode <= `CPI_INIT_MODE_DEFAULT;
			st.cfg.gear_num  <= `CPI_GEAR_DEFAULT;
			st.cfg.gear_den  <= `CPI_GEAR_DEFAULT;
			st.tn.position_loop_time_constant <= `CPI_TP_DEFAULT;
			st.tn.speed_loop_time_constant    <= `CPI_TV_DEFAULT;
			st.tn.acceleration_loop_gain      <= `CPI_KA_DEFAULT;
		end
		else
			st <= next_st;
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign active_cfg        = st.cfg;
	assign tune              = st.tn;
	assign tune_rejected     = st.rej;
	assign oper_mode         = st.cfg.init_mode;
	assign gear_scales_speed = (st.cfg.init_mode == `CPI_MODE_PULSE);
	assign cmd_step          = st.stp;
	assign step_weight       = st.wt;
	assign scaled_count      = st.cnt;
	assign gear_residue      = st.acc;
endmodule

// file: src/cpi_cfg.svh
`ifndef CPI_CFG_SVH
`define CPI_CFG_SVH
`define CPI_MODE_DEFAULT      16'h2110
`define CPI_INIT_MODE_DEFAULT 8'h1D
`define CPI_GEAR_DEFAULT      15'h0064
`define CPI_TP_DEFAULT        15'h0008
`define CPI_TV_DEFAULT        15'h0002
`define CPI_KA_DEFAULT        15'h0005
`define CPI_TUNE_MIN          15'h0001
`define CPI_TYPE_QUAD         4'h0
`define CPI_TYPE_SIGN         4'h1
`define CPI_TYPE_FWDREV       4'h2
`define CPI_MULT_X1           4'h1
`define CPI_MULT_X2           4'h2
`define CPI_MULT_X4           4'h4
`define CPI_MODE_PULSE        8'h1D
`define CPI_ENC_RES           32'h0080_0000
`define CPI_TYPE_LSB          12
`define CPI_DIR_LSB           8
`define CPI_MULT_LSB          4
`endif

// file: src/cpi_pkg.sv
package cpi_pkg;
	typedef struct packed
	{
		logic [15:0] mode_word;
		logic [7:0]  init_mode;
		logic [14:0] gear_num;
		logic [14:0] gear_den;
	} cpi_cfg_t;
	typedef struct packed
	{
		logic [14:0] position_loop_time_constant;
		logic [14:0] speed_loop_time_constant;
		logic [14:0] acceleration_loop_gain;
	} cpi_tune_t;
	typedef struct packed
	{
		logic step;
		logic dir;
	} cpi_step_t;
	typedef enum logic [2:0]
	{
		CPI_IN_QUAD   = 3'b001,
		CPI_IN_SIGN   = 3'b010,
		CPI_IN_FWDREV = 3'b100
	} cpi_in_t;
endpackage

// file: src/cpi_sync.sv
`timescale 1ns/1ps
module cpi_sync
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [2:0] pin,
	output logic      [2:0] level
);
	import cpi_pkg::*;
	typedef struct packed
	{
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] lvl;
	} cpi_sync_st_t;
	cpi_sync_st_t st;
	cpi_sync_st_t next_st;
	// ----------------------------------------
	// Three stages, change taken when 2 and 3 agree
	// ----------------------------------------
	always_comb
	begin
		next_st    = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 3; i++)
		begin
			if (st.s2[i] == st.s3[i])
				next_st.lvl[i] = st.s3[i];
		end
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end
	assign level = st.lvl;
endmodule

// file: tb/cpi_front_checker.sv
`timescale 1ns/1ps
module cpi_front_checker
(
	input wire logic               core_clk,
	input wire logic               rst,
	input wire cpi_pkg::cpi_cfg_t  stored_cfg,
	input wire cpi_pkg::cpi_cfg_t  active_cfg,
	input wire cpi_pkg::cpi_tune_t tune_in,
	input wire logic               tune_load,
	input wire cpi_pkg::cpi_tune_t tune,
	input wire logic               tune_rejected,
	input wire logic [7:0]         oper_mode,
	input wire logic               gear_scales_speed,
	input wire cpi_pkg::cpi_step_t cmd_step,
	input wire logic [2:0]         step_weight,
	input wire logic signed [31:0] scaled_count
);
	import cpi_pkg::*;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	logic ok;
	assign ok = |tune_in.position_loop_time_constant && |tune_in.speed_loop_time_constant
		&& |tune_in.acceleration_loop_gain;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Two edges of grace: the first edge after release latches the stored image
	property p_cfg_hold; !$past(rst, 2) |=> $stable(active_cfg); endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
	// First edge after release must adopt the stored image, initial mode included
	property p_mode; $past(rst) |=> active_cfg == $past(stored_cfg) && oper_mode == $past(stored_cfg.init_mode); endproperty
	a_mode: assert property (p_mode) else $error("mode differs");
	property p_speed; !$past(rst, 2) |-> gear_scales_speed == (oper_mode == 8'h1D); endproperty
	a_speed: assert property (p_speed) else $error("speed scaling wrong");
	property p_pulse; cmd_step.step |=> !cmd_step.step; endproperty
	a_pulse: assert property (p_pulse) else $error("step too long");
	property p_weight; step_weight == {2'h0, cmd_step.step}; endproperty
	a_weight: assert property (p_weight) else $error("weight idle");
	property p_count; $changed(scaled_count) |-> cmd_step.step || $past(cmd_step.step); endproperty
	a_count: assert property (p_count) else $error("count moved");
	property p_tune_bad; tune_load && !ok |=> tune_rejected && $stable(tune); endproperty
	a_tune_bad: assert property (p_tune_bad) else $error("zero tune");
	property p_tune_ok; tune_load && ok |=> tune == $past(tune_in) && !tune_rejected; endproperty
	a_tune_ok: assert property (p_tune_ok) else $error("tune not taken");
	property p_tune_hold; !tune_load |=> $stable(tune); endproperty
	a_tune_hold: assert property (p_tune_hold) else $error("tune drift");
endmodule
bind cpi_front cpi_front_checker cpi_front_checker_i (.*);

// file: tb/cpi_pulse_src.sv
`timescale 1ns/1ps
module cpi_pulse_src
(
	input  wire logic core_clk,
	output logic      pin_a,
	output logic      pin_b,
	output logic      pin_sign
);
	// ----------------------------------------
	// Pulse generator
	// ----------------------------------------
	// Levels held 4 cycles, above the 2-cycle spacing the front end needs
	initial {pin_a, pin_b, pin_sign} = 3'h0;
	task automatic unit(input logic [3:0] kind, input logic rev);
		logic [7:0] seq;
		seq = rev ? 8'h78 : 8'hB4;
		if (kind == 4'h0)
			for (int i = 3; i >= 0; i--)
			begin
				@(posedge core_clk) {pin_a, pin_b} <= seq[2*i +: 2];
				repeat (3) @(posedge core_clk);
			end
		else
		begin
			@(posedge core_clk) pin_sign <= rev;
			repeat (4) @(posedge core_clk);
			if (kind == 4'h2 && !rev)
				pin_a <= 1'b1;
			else
				pin_b <= 1'b1;
			repeat (4) @(posedge core_clk);
			{pin_a, pin_b} <= 2'h0;
			repeat (4) @(posedge core_clk);
		end
	endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cpi_pkg::*;
	logic               core_clk, rst, pin_a, pin_b, pin_sign, tune_load, tune_rejected, gear_scales_speed;
	cpi_cfg_t           stored_cfg, active_cfg;
	cpi_tune_t          tune_in, tune, t;
	cpi_step_t          cmd_step;
	logic [7:0]         oper_mode;
	logic [2:0]         step_weight;
	logic signed [31:0] scaled_count;
	logic [31:0]        gear_residue;
	integer             seed = 6619, n_errors = 0, checks_done = 0, n_steps, den, num, n;
	logic               last_dir, rv;
	logic [15:0]        modes [6] = '{16'h0010, 16'h0120, 16'h0140, 16'h1010, 16'h1110, 16'h2010};
	int                 weights [6] = '{1, 2, 4, 1, 1, 1};
	cpi_front cpi_front_i (.*);
	cpi_pulse_src cpi_pulse_src_i (.*);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (cmd_step.step === 1'b1)
		begin
			n_steps = n_steps + 1;
			last_dir = cmd_step.dir;
		end
	function automatic logic [63:0] mag(input logic signed [31:0] v);
		return v < 0 ? -v : v;
	endfunction
	// Whole steps and leftover fraction after p pulses through a nu/de gear
	function automatic int gear_pos(input int p, input int nu, input int de);
		return p * nu / de;
	endfunction
	function automatic int gear_res(input int p, input int nu, input int de);
		return p * nu % de;
	endfunction
	task automatic cmp(input string s, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge core_clk) rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic load(input cpi_tune_t v);
		@(posedge core_clk) tune_in <= v;
		tune_load <= 1'b1;
		@(posedge core_clk) tune_load <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	initial
	begin
		#400000;
		n_errors++;
		give_verdict();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		stored_cfg = '{16'h0140, 8'h05, 15'h0007, 15'h0003};
		tune_in = '0;
		tune_load = 1'b0;
		repeat (2) @(posedge core_clk);
		cmp("cfg", {16'h2110, 8'h1D, 15'h0064, 15'h0064}, active_cfg);
		cmp("tune", {15'h0008, 15'h0002, 15'h0005}, tune);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			den = 1 + {$random(seed)} % 100;
			num = 2 * den + {$random(seed)} % den;
			stored_cfg <= '{modes[i], i[0] ? 8'h1D : 8'($random(seed)), 15'(num), 15'(den)};
			do_reset();
			cmp("cfg", stored_cfg, active_cfg);
			stored_cfg <= '{16'h2140, 8'h1D, 15'h0001, 15'h0001};
			n_steps = 0;
			rv = $random(seed);
			n = 1 + {$random(seed)} % 3;
			repeat (n) cpi_pulse_src_i.unit(modes[i][15:12], rv);
			repeat (8) @(posedge core_clk);
			cmp("steps", n * weights[i], n_steps);
			if (modes[i][15:12] != 4'h0 || modes[i][11:8] == 4'h0)
				cmp("dir", rv, last_dir);
			cmp("pos", gear_pos(n * weights[i], num, den), mag(scaled_count));
			cmp("residue", gear_res(n * weights[i], num, den), gear_residue);
		end
		t = '{15'h0001, 15'h7FFF, 15'($random(seed)) | 15'h0001};
		load(t);
		cmp("tune", t, tune);
		load('{15'h0005, 15'h0000, 15'h0009});
		cmp("tune", t, tune);
		cmp("rejected", 1'b1, tune_rejected);
		do_reset();
		cmp("tune", {15'h0008, 15'h0002, 15'h0005}, tune);
		give_verdict();
	end
endmodule
